// *** design/nbp_packer.sv ***
// Behaviour
// [R1] Each variable brings its own layout map, captured at frame start.
// [R2] Layout map is a 32-bit value.
// [R3] Map bits 0..30 belong to bytes 0..30, LSB first.
// [R4] Variables hold at most 31 bytes; extra bytes are dropped.
// [R5] Byte stream assembled into 16-bit register words.
// [R6] Map bit 31 low packs, high unpacks.
// [R7] Unpacked single byte fills low byte, high byte zero.
// [R8] Packed single bytes pair low then high in one register.
// [R9] Element start bit 0 is single byte, 1 joins next byte.
// [R10] After joining byte, 0 ends word, 1 starts double word.
// [R11] Configurer keeps upper double word bits zero.
// [R12] Array elements continue into following registers.
// [R13] Words start in fresh register, closing pending half.
// [R14] Output direction splits registers back to bytes via map.
`timescale 1ns/1ps
`include "nbp_regs.svh"
module nbp_packer #(
	parameter int FIFO_DEPTH = `NBP_FIFO_DEPTH
) (
	input  wire logic                        mclk_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        dir_out_in,
	input  wire logic [`NBP_MAP_W-1:0]       map_in,
	input  wire logic [`NBP_REG_ADDR_W-1:0]  base_in,
	input  wire logic                        start_in,
	input  wire logic                        last_in,
	input  wire logic [`NBP_BYTE_W-1:0]      nbyte_in,
	input  wire logic                        nvalid_in,
	output logic                             nready_out,
	output logic [`NBP_BYTE_W-1:0]           nbyte_out,
	output logic                             nvalid_out,
	output logic                             nlast_out,
	input  wire logic                        nready_in,
	output logic [`NBP_REG_ADDR_W-1:0]       reg_addr_out,
	output logic [`NBP_REG_W-1:0]            reg_wdata_out,
	output logic                             reg_we_out,
	output logic                             reg_re_out,
	input  wire logic [`NBP_REG_W-1:0]       reg_rdata_in,
	output logic                             busy_out
);
	nbp_pkg::nbp_state_t           st_r;
	nbp_pkg::nbp_state_t           st_nxt;
	// [R2] 32-bit layout map
	logic [`NBP_MAP_W-1:0]         map_r;
	logic [`NBP_MAP_W-1:0]         map_nxt;
	logic [`NBP_REG_ADDR_W-1:0]    addr_r;
	logic [`NBP_REG_ADDR_W-1:0]    addr_nxt;
	logic [`NBP_CNT_W-1:0]         idx_r;
	logic [`NBP_CNT_W-1:0]         idx_nxt;
	logic                          join_r;
	logic                          join_nxt;
	logic                          half_r;
	logic                          half_nxt;
	logic                          dw_r;
	logic                          dw_nxt;
	logic [`NBP_BYTE_W-1:0]        lo_r;
	logic [`NBP_BYTE_W-1:0]        lo_nxt;
	logic [`NBP_REG_W-1:0]         wd_r;
	logic [`NBP_REG_W-1:0]         wd_nxt;
	logic                          we_r;
	logic                          we_nxt;
	logic                          re_r;
	logic                          re_nxt;
	logic [`NBP_REG_W-1:0]         rd_r;
	logic [`NBP_REG_W-1:0]         rd_nxt;
	logic                          rdv_r;
	logic                          rdv_nxt;
	logic [`NBP_REG_ADDR_W-1:0]    oaddr_r;
	logic [`NBP_REG_ADDR_W-1:0]    oaddr_nxt;
	logic [`NBP_BYTE_W-1:0]        fb;
	logic                          fv;
	logic                          fr;
	logic [`NBP_BYTE_W-1:0]        ob;
	logic                          ov;
	logic                          or_;
	logic                          olast;
	logic [`NBP_BYTE_W:0]          opk;
	logic [`NBP_BYTE_W:0]          opk_q;
	logic                          cur_bit;
	logic                          packed_m;
	logic                          in_ok;
	logic                          out_ok;
	logic                          wstart;
	// [R3] Map bit for byte position
	function automatic logic map_bit(input logic [`NBP_MAP_W-1:0] m,
		input logic [`NBP_CNT_W-1:0] i);
		map_bit = m[i];
	endfunction : map_bit
	// [R5] Input bytes buffered for packing
	nbp_fifo #(.WIDTH(`NBP_BYTE_W), .DEPTH(FIFO_DEPTH)) u_ififo (
		.mclk_in       (mclk_in),
		.rst_n_in      (rst_n_in),
		.in_data_in    (nbyte_in),
		.in_valid_in   (nvalid_in && !dir_out_in),
		.in_ready_out  (nready_out),
		.out_data_out  (fb),
		.out_valid_out (fv),
		.out_ready_in  (fr)
	);
	// Byte buffering on network output side
	nbp_fifo #(.WIDTH(`NBP_BYTE_W+1), .DEPTH(FIFO_DEPTH)) u_ofifo (
		.mclk_in       (mclk_in),
		.rst_n_in      (rst_n_in),
		.in_data_in    (opk),
		.in_valid_in   (ov),
		.in_ready_out  (or_),
		.out_data_out  (opk_q),
		.out_valid_out (nvalid_out),
		.out_ready_in  (nready_in)
	);
	assign nbyte_out = opk_q[`NBP_BYTE_W-1:0];
	assign nlast_out = opk_q[`NBP_BYTE_W];
	assign opk       = {olast, ob};
	assign reg_addr_out  = dir_out_in ? oaddr_r : addr_r;
	assign reg_wdata_out = wd_r;
	assign reg_we_out    = we_r;
	assign reg_re_out    = re_r;
	assign busy_out      = (st_r != nbp_pkg::NBP_IDLE);
	// [R6] Packing mode select
	assign packed_m = (map_r[`NBP_MODE_BIT] == `NBP_MODE_PACKED);
	assign cur_bit  = map_bit(map_r, idx_r);
	assign wstart   = cur_bit || dw_r;
	assign in_ok    = (st_r == nbp_pkg::NBP_RUN) && !dir_out_in && fv;
	assign fr       = in_ok || (st_r == nbp_pkg::NBP_IDLE && fv && !start_in
		&& !dir_out_in);
	assign out_ok   = (st_r == nbp_pkg::NBP_RUN) && dir_out_in && rdv_r && or_;
	always_comb begin
		st_nxt    = st_r;
		map_nxt   = map_r;
		addr_nxt  = addr_r;
		idx_nxt   = idx_r;
		join_nxt  = join_r;
		half_nxt  = half_r;
		dw_nxt    = dw_r;
		lo_nxt    = lo_r;
		wd_nxt    = wd_r;
		we_nxt    = 1'b0;
		re_nxt    = 1'b0;
		rd_nxt    = rd_r;
		rdv_nxt   = rdv_r;
		oaddr_nxt = oaddr_r;
		ob        = '0;
		ov        = 1'b0;
		olast     = 1'b0;
		if (re_r) begin
			rd_nxt  = reg_rdata_in;
			rdv_nxt = 1'b1;
		end
		// [R12] Next write goes one register up
		if (we_r) begin
			addr_nxt = addr_r + 1'b1;
		end
		unique case (st_r)
			nbp_pkg::NBP_IDLE: begin
				// [R1] Map captured per variable
				if (start_in) begin
					map_nxt   = map_in;
					addr_nxt  = base_in;
					oaddr_nxt = base_in;
					idx_nxt   = '0;
					join_nxt  = 1'b0;
					half_nxt  = 1'b0;
					dw_nxt    = 1'b0;
					rdv_nxt   = 1'b0;
					re_nxt    = dir_out_in;
					st_nxt    = nbp_pkg::NBP_RUN;
				end
			end
			nbp_pkg::NBP_RUN: begin
				if (in_ok) begin
					if (idx_r == 5'(`NBP_MAX_BYTES)) begin
						// [R4] Overlong variable bytes discarded
						dw_nxt = 1'b0;
					end else if (join_r) begin
						// [R10] Second byte closes word
						wd_nxt   = {fb, lo_r};
						we_nxt   = 1'b1;
						join_nxt = 1'b0;
						dw_nxt   = cur_bit;
						idx_nxt  = idx_r + 1'b1;
					end else if (wstart) begin
						// [R9] Word starts in fresh register
						if (half_r) begin
							wd_nxt   = {8'h00, lo_r};
							we_nxt   = 1'b1;
							half_nxt = 1'b0;
						end
						lo_nxt   = fb;
						join_nxt = 1'b1;
						dw_nxt   = 1'b0;
						idx_nxt  = idx_r + 1'b1;
					end else if (!packed_m) begin
						// [R7] Unpacked single byte low
						wd_nxt   = {8'h00, fb};
						we_nxt   = 1'b1;
						idx_nxt  = idx_r + 1'b1;
					end else if (half_r) begin
						// [R8] Packed pair low then high
						wd_nxt   = {fb, lo_r};
						we_nxt   = 1'b1;
						half_nxt = 1'b0;
						idx_nxt  = idx_r + 1'b1;
					end else begin
						lo_nxt   = fb;
						half_nxt = 1'b1;
						idx_nxt  = idx_r + 1'b1;
					end
					if (last_in) begin
						st_nxt = nbp_pkg::NBP_FLSH;
					end
				end
				// [R14] Registers split back to bytes
				if (out_ok) begin
					olast = (idx_r == 5'(`NBP_MAX_BYTES-1)) || last_in;
					ov    = !(half_r && wstart);
					if (join_r || half_r) begin
						// [R13] Empty upper half skipped before word
						ob        = rd_r[15:8];
						dw_nxt    = join_r && cur_bit;
						join_nxt  = 1'b0;
						half_nxt  = 1'b0;
						rdv_nxt   = 1'b0;
						re_nxt    = !(olast && ov);
						oaddr_nxt = oaddr_r + 1'b1;
					end else begin
						ob     = rd_r[7:0];
						dw_nxt = 1'b0;
						if (wstart || packed_m) begin
							join_nxt = wstart;
							half_nxt = !wstart;
						end else begin
							rdv_nxt   = 1'b0;
							re_nxt    = !olast;
							oaddr_nxt = oaddr_r + 1'b1;
						end
						if (olast && (wstart || packed_m)) begin
							re_nxt = 1'b0;
						end
					end
					if (ov) begin
						idx_nxt = idx_r + 1'b1;
					end
					if (olast && ov) begin
						st_nxt = nbp_pkg::NBP_IDLE;
					end
				end
			end
			nbp_pkg::NBP_FLSH: begin
				// [R13] Array tail flush of half register
				if (half_r || join_r) begin
					wd_nxt   = {8'h00, lo_r};
					we_nxt   = 1'b1;
				end
				half_nxt = 1'b0;
				join_nxt = 1'b0;
				st_nxt   = nbp_pkg::NBP_IDLE;
			end
			default: begin
				st_nxt = nbp_pkg::NBP_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r    <= nbp_pkg::NBP_IDLE;
			map_r   <= '0;
			addr_r  <= '0;
			idx_r   <= '0;
			join_r  <= 1'b0;
			half_r  <= 1'b0;
			dw_r    <= 1'b0;
			lo_r    <= '0;
			wd_r    <= '0;
			we_r    <= 1'b0;
			re_r    <= 1'b0;
			rd_r    <= '0;
			rdv_r   <= 1'b0;
			oaddr_r <= '0;
		end else begin
			st_r    <= st_nxt;
			map_r   <= map_nxt;
			addr_r  <= addr_nxt;
			idx_r   <= idx_nxt;
			join_r  <= join_nxt;
			half_r  <= half_nxt;
			dw_r    <= dw_nxt;
			lo_r    <= lo_nxt;
			wd_r    <= wd_nxt;
			we_r    <= we_nxt;
			re_r    <= re_nxt;
			rd_r    <= rd_nxt;
			rdv_r   <= rdv_nxt;
			oaddr_r <= oaddr_nxt;
		end
	end
endmodule : nbp_packer

// *** design/nbp_regs.svh ***
`ifndef NBP_REGS_SVH
`define NBP_REGS_SVH
`define NBP_MAP_W        32
`define NBP_MODE_BIT     31
`define NBP_MAX_BYTES    31
`define NBP_BYTE_W       8
`define NBP_REG_W        16
`define NBP_REG_ADDR_W   8
`define NBP_CNT_W        5
`define NBP_FIFO_DEPTH   8
`define NBP_MODE_PACKED  1'b0
`define NBP_MODE_UNPACK  1'b1
`endif

// *** design/nbp_pkg.sv ***
package nbp_pkg;
	typedef enum logic [1:0] {
		NBP_IDLE = 2'b00,
		NBP_RUN  = 2'b01,
		NBP_FLSH = 2'b11
	} nbp_state_t;
	typedef enum logic [1:0] {
		NBP_EL_BYTE = 2'b00,
		NBP_EL_WLO  = 2'b01,
		NBP_EL_WHI  = 2'b10
	} nbp_elem_t;
endpackage : nbp_pkg

// *** design/nbp_fifo.sv ***
`timescale 1ns/1ps
module nbp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    wp_nxt;
	logic [AW-1:0]    rp_r;
	logic [AW-1:0]    rp_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             wr;
	logic             rd;

	assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out  = mem_r[rp_r];

	always_comb begin
		wr      = in_valid_in && in_ready_out;
		rd      = out_valid_out && out_ready_in;
		wp_nxt  = wr ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
		rp_nxt  = rd ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (wr) begin
			mem_r[wp_r] <= in_data_in;
		end
	end
endmodule : nbp_fifo

// *** verification/nbp_packer_monitor.sv ***
`timescale 1ns/1ps
module nbp_packer_monitor (
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	input  wire logic        dir_out_in,
	input  wire logic [31:0] map_in,
	input  wire logic [7:0]  base_in,
	input  wire logic        start_in,
	input  wire logic        busy_out,
	input  wire logic [7:0]  reg_addr_out,
	input  wire logic [15:0] reg_wdata_out,
	input  wire logic        reg_we_out,
	input  wire logic        reg_re_out
);
	logic [31:0] map_r;
	logic [7:0]  base_r;
	logic [7:0]  last_r;
	logic [5:0]  cnt_r;
	logic        first_r;
	wire         acc = reg_we_out | reg_re_out;
	wire         go  = start_in & ~busy_out;
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			map_r   <= '0;
			base_r  <= '0;
			last_r  <= '0;
			cnt_r   <= '0;
			first_r <= 1'b0;
		end else if (go) begin
			map_r   <= map_in;
			base_r  <= base_in;
			cnt_r   <= '0;
			first_r <= 1'b1;
		end else if (acc) begin
			last_r  <= reg_addr_out;
			cnt_r   <= cnt_r + 6'h01;
			first_r <= 1'b0;
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_go;
		go;
	endsequence
	property p_start_busy;
		s_go |=> busy_out;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("no busy after start");
	property p_first;
		acc && first_r |-> reg_addr_out == base_r;
	endproperty
	a_first: assert property (p_first)
		else $error("first access off base");
	property p_next;
		acc && !first_r |-> reg_addr_out == last_r + 8'h01;
	endproperty
	a_next: assert property (p_next)
		else $error("access not in next register");
	property p_max;
		acc |-> cnt_r < 6'h1f;
	endproperty
	a_max: assert property (p_max)
		else $error("too many registers");
	property p_in_dir;
		busy_out && !dir_out_in |-> !reg_re_out;
	endproperty
	a_in_dir: assert property (p_in_dir)
		else $error("read in input direction");
	property p_out_dir;
		busy_out && dir_out_in |-> !reg_we_out;
	endproperty
	a_out_dir: assert property (p_out_dir)
		else $error("write in output direction");
	property p_unpk;
		reg_we_out && map_r == 32'h80000000 |-> reg_wdata_out[15:8] == 8'h00;
	endproperty
	a_unpk: assert property (p_unpk)
		else $error("upper byte not empty");
	property p_hold;
		!reg_we_out |-> $stable(reg_wdata_out);
	endproperty
	a_hold: assert property (p_hold)
		else $error("data moved without write");
endmodule : nbp_packer_monitor
bind nbp_packer nbp_packer_monitor i_mon (.mclk_in, .rst_n_in, .dir_out_in,
	.map_in, .base_in, .start_in, .busy_out, .reg_addr_out, .reg_wdata_out,
	.reg_we_out, .reg_re_out);

// *** verification/nbp_reg_model.sv ***
`timescale 1ns/1ps
module nbp_reg_model (
	input  wire logic        mclk_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        we_in,
	input  wire logic        re_in,
	output logic      [15:0] rdata_out
);
	logic [15:0] mem_r [256];
	logic [15:0] last_r = 16'h0000;
	initial foreach (mem_r[i]) mem_r[i] = 16'h5a5a;
	always @(posedge mclk_in) begin
		if (we_in) mem_r[addr_in] <= wdata_in;
		if (re_in) last_r <= mem_r[addr_in];
	end
	// Read data stands with the strobe, stale data inverted
	assign rdata_out = re_in ? mem_r[addr_in] : ~last_r;
endmodule : nbp_reg_model

// *** verification/test_nbp_packer.sv ***
`timescale 1ns/1ps
module test_nbp_packer;
	logic        mclk_in = 1'b0, rst_n_in = 1'b0, dir_out_in = 1'b0;
	logic [31:0] map_in = '0;
	logic [7:0]  base_in = '0, nbyte_in = '0, nbyte_out, reg_addr_out;
	logic        start_in = 1'b0, last_in = 1'b0, nvalid_in = 1'b0;
	logic        nready_in = 1'b1, nready_out, nvalid_out, nlast_out;
	logic        reg_we_out, reg_re_out, busy_out;
	logic [15:0] reg_wdata_out, reg_rdata_in;
	int          error_cnt = 0, samples_checked = 0, cyc = 0;
	logic [15:0] exp_u [9] = '{16'h00a1, 16'h00a2, 16'ha4a3, 16'h00a5,
		16'ha7a6, 16'ha9a8, 16'habaa, 16'h00ac, 16'h00ad};
	logic [15:0] exp_p [7] = '{16'ha2a1, 16'ha4a3, 16'h00a5, 16'ha7a6,
		16'ha9a8, 16'habaa, 16'hadac};
	always #5 mclk_in = ~mclk_in;
	nbp_packer i_dut (.mclk_in, .rst_n_in, .dir_out_in, .map_in, .base_in,
		.start_in, .last_in, .nbyte_in, .nvalid_in, .nready_out, .nbyte_out,
		.nvalid_out, .nlast_out, .nready_in, .reg_addr_out, .reg_wdata_out,
		.reg_we_out, .reg_re_out, .reg_rdata_in, .busy_out);
	nbp_reg_model i_reg (.mclk_in, .addr_in(reg_addr_out),
		.wdata_in(reg_wdata_out), .we_in(reg_we_out), .re_in(reg_re_out),
		.rdata_out(reg_rdata_in));
	task stop_test;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test
	task check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task wait_idle;
		int n;
		n = 0;
		do begin
			@(negedge mclk_in);
			n++;
		end while (busy_out !== 1'b0 && n < 300);
		check({15'h0000, busy_out}, 16'h0000);
		@(posedge mclk_in);
	endtask : wait_idle
	task push(input logic [7:0] b, input logic l);
		nbyte_in  <= b;
		nvalid_in <= 1'b1;
		last_in   <= l;
		do @(negedge mclk_in); while (nready_out !== 1'b1);
		@(posedge mclk_in);
	endtask : push
	task frame(input logic [31:0] m, input logic [7:0] b, input int n);
		@(posedge mclk_in);
		map_in   <= m;
		base_in  <= b;
		start_in <= 1'b1;
		@(posedge mclk_in);
		start_in <= 1'b0;
		for (int k = 1; k <= n; k++) push(8'ha0 + k[7:0], 1'b0);
		// Frame end marked once last byte is taken
		nvalid_in <= 1'b0;
		last_in   <= 1'b1;
		wait_idle();
		last_in <= 1'b0;
	endtask : frame
	task t_unpacked;
		frame(32'h800001a4, 8'h10, 13);
		for (int i = 0; i < 9; i++) check(i_reg.mem_r[8'h10 + i], exp_u[i]);
		check(i_reg.mem_r[8'h19], 16'h5a5a);
	endtask : t_unpacked
	task t_packed;
		frame(32'h000001a4, 8'h20, 13);
		for (int i = 0; i < 7; i++) check(i_reg.mem_r[8'h20 + i], exp_p[i]);
		check(i_reg.mem_r[8'h27], 16'h5a5a);
	endtask : t_packed
	task t_limit;
		frame(32'h80000000, 8'h40, 33);
		for (int i = 0; i < 31; i++)
			check(i_reg.mem_r[8'h40 + i], {8'h00, 8'ha1 + i[7:0]});
		check(i_reg.mem_r[8'h5f], 16'h5a5a);
	endtask : t_limit
	task t_output;
		logic [15:0] e;
		for (int i = 0; i < 7; i++) i_reg.mem_r[8'h80 + i] = exp_p[i];
		@(posedge mclk_in);
		dir_out_in <= 1'b1;
		nready_in  <= 1'b0;
		map_in     <= 32'h000001a4;
		base_in    <= 8'h80;
		start_in   <= 1'b1;
		@(posedge mclk_in);
		start_in <= 1'b0;
		repeat (20) @(posedge mclk_in);
		nready_in <= 1'b1;
		// Untouched registers beyond the variable read back as 5a
		for (int k = 1; k <= 31; k++) begin
			do @(negedge mclk_in); while (nvalid_out !== 1'b1);
			e = (k <= 13) ? 16'h00a0 + 16'(k) : 16'h005a;
			check({8'h00, nbyte_out}, e);
			check({15'h0000, nlast_out}, 16'(k == 31));
			@(posedge mclk_in);
		end
		wait_idle();
		dir_out_in <= 1'b0;
	endtask : t_output
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		repeat (20) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		t_unpacked();
		t_packed();
		t_limit();
		t_output();
		stop_test();
	end
endmodule : test_nbp_packer
